// ===== stf_pkg.sv
// Package with the startup-timeout fault handler's constants and types.
package stf_pkg;

  // Register offsets within the command space.
  localparam logic [7:0] STF_ACTION_OFFSET   = 8'h63;
  localparam logic [7:0] STF_TIME_UNIT_OFFSET = 8'hd2;

  // Field positions of the action byte.
  localparam int STF_RESP_LSB  = 6;
  localparam int STF_RETRY_LSB = 3;
  localparam int STF_DELAY_LSB = 0;

  // Value after reset of the action byte: disable until cleared, no retry.
  localparam logic [7:0] STF_ACTION_RESET = 8'hc0;

  // Response codes.
  localparam logic [1:0] STF_RESP_IGNORE  = 2'h0;
  localparam logic [1:0] STF_RESP_RUN     = 2'h1;
  localparam logic [1:0] STF_RESP_RETRY   = 2'h2;
  localparam logic [1:0] STF_RESP_LATCH   = 2'h3;

  // Retry count codes.
  localparam logic [2:0] STF_RETRY_NONE    = 3'h0;
  localparam logic [2:0] STF_RETRY_FOREVER = 3'h7;

  // Clock rate and the default length of one delay time unit.
  localparam int STF_CLK_HZ      = 10_000_000;
  localparam int STF_UNIT_US     = 1000;
  localparam int STF_UNIT_CYCLES = STF_UNIT_US * (STF_CLK_HZ / 1_000_000);

  // Byte write from the command interface.
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } stf_cmd_t;

  // Events that clear a latched fault.
  typedef struct packed {
    logic clear_bit;
    logic clear_faults;
    logic reset_cmd;
    logic bias_lost;
  } stf_clear_t;

  typedef enum logic [2:0] {
    STF_ST_IDLE,
    STF_ST_RUN_DELAY,
    STF_ST_OFF_WAIT,
    STF_ST_RESTART,
    STF_ST_LATCHED
  } stf_state_t;

endpackage

// ===== stf_tick_div.sv
// Divider that makes a one-cycle delay-expiry pulse.
`timescale 1ns/100ps
module stf_tick_div #(
  parameter int UNIT_CYCLES = 10000
) (
  input  wire logic       ref_clk,   // System clock.
  input  wire logic       srst,      // Synchronous reset, active high.
  input  wire logic       start,     // Restart the count from zero.
  input  wire logic [2:0] exp_sel,   // Delay code n: wait 2**n units.
  output logic            done       // Pulse when the delay has elapsed.
);
  import stf_pkg::*;

  logic [31:0] cyc_reg;
  logic [7:0]  units_reg;
  logic        busy_reg;
  logic [7:0]  units_goal;

  assign units_goal = 8'h01 << exp_sel;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cyc_reg   <= '0;
      units_reg <= '0;
      busy_reg  <= 1'b0;
      done      <= 1'b0;
    end else if (start) begin
      cyc_reg   <= '0;
      units_reg <= '0;
      busy_reg  <= 1'b1;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (busy_reg) begin
        if (cyc_reg == 32'(UNIT_CYCLES - 1)) begin
          cyc_reg <= '0;
          if (units_reg + 8'h01 == units_goal) begin
            busy_reg <= 1'b0;
            done     <= 1'b1;
          end else begin
            units_reg <= units_reg + 8'h01;
          end
        end else begin
          cyc_reg <= cyc_reg + 32'h1;
        end
      end
    end
  end
endmodule

// ===== stf_core.sv
// Startup-timeout fault response: shutdown, retry and latch-off sequencing.
//
// Overview of operation
// - Code 10: on fault disable output, then follow the retry count field.
// - Code 11: disable on fault and stay off, latched, until cleared.
// - Latch clears on bit clear, CLEAR_FAULTS, reset, off-on cycle, bias loss.
// - Retry code 000: no restart; output stays off until fault cleared.
// - Codes 001..110 allow one to six restarts, then stay off latched.
// - Restart attempts start two to the delay code time units apart.
// - Retry code 111 retries forever until commanded off, bias lost or another fault.
// - Delay code n means two to the n time units.
// - Delay is run time after fault or spacing between restarts.
// - Time unit is fixed by the UNIT_CYCLES parameter; no register setting selects it.
// - Response 00 ignores the fault and keeps running.
// - Response 01 runs for the delay, then follows the retry count field if fault persists.
// - Fault is raised when output misses threshold in limit; zero disables.
`timescale 1ns/100ps
module stf_core #(
  parameter int UNIT_CYCLES = stf_pkg::STF_UNIT_CYCLES
) (
  input  wire logic               ref_clk,      // System clock, 10 MHz.
  input  wire logic               srst,         // Synchronous reset.
  input  wire stf_pkg::stf_cmd_t  cmd,          // Byte write from host.
  input  wire stf_pkg::stf_clear_t clr,         // Fault clearing events.
  input  wire logic               on_cmd,       // Output commanded on.
  input  wire logic               uv_ok_pin,    // Output above UV threshold.
  input  wire logic               limit_zero,   // Timeout limit is zero.
  input  wire logic               timeout_pin,  // Timeout expired, raw.
  input  wire logic               other_fault,  // Other fault shut down.
  output logic [7:0]              action_rd,    // Action byte readback.
  output logic                    out_en,       // Output enable.
  output logic                    fault_latched,// Fault latched, off.
  output logic                    fault_seen,   // Startup timeout pending.
  output logic [2:0]              attempts      // Restarts made so far.
);
  import stf_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [1:0] uv_sync_reg;
  logic [1:0] to_sync_reg;
  logic       uv_ok;
  logic       timeout_raw;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      uv_sync_reg <= '0;
      to_sync_reg <= '0;
    end else begin
      uv_sync_reg <= {uv_sync_reg[0], uv_ok_pin};
      to_sync_reg <= {to_sync_reg[0], timeout_pin};
    end
  end

  assign uv_ok       = uv_sync_reg[1];
  assign timeout_raw = to_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////
  // Action byte register.

  logic [7:0] action_reg;
  logic [1:0] resp;
  logic [2:0] retry_code;
  logic [2:0] delay_code;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      action_reg <= STF_ACTION_RESET;
    end else if (cmd.wr && cmd.addr == STF_ACTION_OFFSET) begin
      action_reg <= cmd.data;
    end
  end

  assign resp       = action_reg[STF_RESP_LSB +: 2];
  assign retry_code = action_reg[STF_RETRY_LSB +: 3];
  assign delay_code = action_reg[STF_DELAY_LSB +: 3];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      action_rd <= STF_ACTION_RESET;
    end else begin
      action_rd <= action_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fault detection and clearing.

  logic fault;
  logic on_prev_reg;
  logic off_on_cycle;
  logic clear_any;

  // A zero limit means the output may take forever to come up.
  assign fault = timeout_raw && !limit_zero && !uv_ok;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      on_prev_reg <= 1'b0;
    end else begin
      on_prev_reg <= on_cmd;
    end
  end

  // Only the rising edge of on is a clearing event; the fall merely stops.
  assign off_on_cycle = on_cmd && !on_prev_reg;
  assign clear_any    = clr.clear_bit || clr.clear_faults ||
                        clr.reset_cmd || clr.bias_lost || off_on_cycle;

  ////////////////////////////////////////////////////////////////////////
  // Delay timer.

  logic timer_start;
  logic timer_done;

  stf_tick_div #(
    .UNIT_CYCLES (UNIT_CYCLES)
  ) u_div (
    .ref_clk (ref_clk),
    .srst    (srst),
    .start   (timer_start),
    .exp_sel (delay_code),
    .done    (timer_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Response sequencer.

  stf_state_t state_reg;
  logic [2:0] count_reg;
  logic       stop;
  logic       retries_left;

  // Another fault, bias loss or command off ends the off-wait between restarts.
  assign stop = !on_cmd || clr.bias_lost || other_fault;
  assign retries_left = (retry_code == STF_RETRY_FOREVER) ||
                        (count_reg < retry_code);

  assign timer_start = (state_reg == STF_ST_IDLE && fault &&
                        resp == STF_RESP_RUN) ||
                       (state_reg == STF_ST_RUN_DELAY && timer_done &&
                        fault) ||
                       (state_reg == STF_ST_IDLE && fault &&
                        resp == STF_RESP_RETRY) ||
                       (state_reg == STF_ST_RESTART && fault);

  always_ff @(posedge ref_clk) begin
    if (srst || clear_any) begin
      state_reg <= STF_ST_IDLE;
      count_reg <= '0;
    end else begin
      case (state_reg)
        STF_ST_IDLE: begin
          if (fault) begin
            case (resp)
              STF_RESP_IGNORE: state_reg <= STF_ST_IDLE;
              STF_RESP_RUN:    state_reg <= STF_ST_RUN_DELAY;
              STF_RESP_RETRY:  state_reg <= STF_ST_OFF_WAIT;
              default:         state_reg <= STF_ST_LATCHED;
            endcase
          end
        end
        STF_ST_RUN_DELAY: begin
          // Delay here is run time while the output stays on.
          if (!fault) begin
            state_reg <= STF_ST_IDLE;
          end else if (timer_done) begin
            state_reg <= STF_ST_OFF_WAIT;
          end
        end
        STF_ST_OFF_WAIT: begin
          if (retry_code == STF_RETRY_NONE) begin
            state_reg <= STF_ST_LATCHED;
          end else if (stop) begin
            state_reg <= STF_ST_LATCHED;
          end else if (timer_done) begin
            if (retries_left) begin
              state_reg <= STF_ST_RESTART;
              if (retry_code != STF_RETRY_FOREVER) begin
                count_reg <= count_reg + 3'h1;
              end
            end else begin
              state_reg <= STF_ST_LATCHED;
            end
          end
        end
        STF_ST_RESTART: begin
          if (uv_ok) begin
            state_reg <= STF_ST_IDLE;
            count_reg <= '0;
          end else if (fault) begin
            state_reg <= STF_ST_OFF_WAIT;
          end
        end
        default: begin
          state_reg <= STF_ST_LATCHED;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs.

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      out_en        <= 1'b0;
      fault_latched <= 1'b0;
      fault_seen    <= 1'b0;
      attempts      <= '0;
    end else begin
      out_en <= on_cmd && state_reg != STF_ST_OFF_WAIT &&
                state_reg != STF_ST_LATCHED;
      fault_latched <= state_reg == STF_ST_LATCHED;
      fault_seen    <= fault;
      attempts      <= count_reg;
    end
  end
endmodule

// ===== stf_core_monitor.sv
// Checker holding the port-level properties of the fault handler.
`timescale 1ns/100ps
module stf_core_monitor #(
  parameter int UNIT_CYCLES = 4
) (
  input wire logic                ref_clk,       // Clock.
  input wire logic                srst,          // Reset.
  input wire stf_pkg::stf_cmd_t   cmd,           // Host write.
  input wire stf_pkg::stf_clear_t clr,           // Clear events.
  input wire logic                on_cmd,        // On command.
  input wire logic                uv_ok_pin,     // Output good.
  input wire logic                limit_zero,    // No limit.
  input wire logic                timeout_pin,   // Timeout.
  input wire logic                other_fault,   // Other fault.
  input wire logic [7:0]          action_rd,     // Action byte.
  input wire logic                out_en,        // Output enable.
  input wire logic                fault_latched, // Latched off.
  input wire logic                fault_seen,    // Fault pending.
  input wire logic [2:0]          attempts       // Restarts.
);
  import stf_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire logic  w63 = cmd.wr && cmd.addr == STF_ACTION_OFFSET;
  logic [11:0] off_cnt_reg;
  int          gap_min;
  // Off time is counted at the pins, so the gap bound allows a few cycles.
  assign gap_min = (UNIT_CYCLES << action_rd[2:0]) - 2;
  always_ff @(posedge ref_clk) begin
    if (srst || out_en) begin
      off_cnt_reg <= 12'h0;
    end else begin
      off_cnt_reg <= off_cnt_reg + 12'h1;
    end
  end
  chk_write_readback: assert property (
    w63 |-> ##2 action_rd == $past(cmd.data, 2)) else $error("readback");
  chk_write_hold: assert property (
    !w63 ##1 !w63 |=> $stable(action_rd)) else $error("byte changed");
  chk_fault_shutdown: assert property (
    $rose(fault_seen) && action_rd[7:6] == STF_RESP_RETRY |-> ##[1:3] !out_en)
    else $error("no shutdown");
  chk_latch_off: assert property (
    fault_latched |-> !out_en) else $error("latched but on");
  chk_latch_hold: assert property (
    $fell(fault_latched) |-> $past(clr) != '0 || $past(clr, 2) != '0
      || !$past(on_cmd, 2) || !$past(on_cmd, 3)) else $error("latch lost");
  chk_clear_latch: assert property (
    fault_latched && clr.clear_faults |-> ##[1:2] !fault_latched)
    else $error("clear ignored");
  chk_attempt_limit: assert property (
    action_rd[5:3] != STF_RETRY_FOREVER |-> attempts <= action_rd[5:3])
    else $error("too many restarts");
  chk_attempt_step: assert property (
    attempts != $past(attempts) |-> attempts == 3'h0
      || attempts == $past(attempts) + 3'h1) else $error("count jump");
  chk_restart_gap: assert property (
    attempts > $past(attempts) |-> int'(off_cnt_reg) >= gap_min
      && int'(off_cnt_reg) <= gap_min + 6) else $error("restart spacing");
  chk_ignore_fault: assert property (
    action_rd[7:6] == STF_RESP_IGNORE && fault_seen && out_en && on_cmd
      && !other_fault && clr == '0 |=> out_en) else $error("ignored fault");
  cov_latched: cover property (fault_latched);
  cov_six_tries: cover property (attempts == 3'h6);
  cov_ignore: cover property (action_rd[7:6] == 2'h0 && fault_seen);
endmodule

// ===== stf_host_model.sv
// Host model that issues single-byte command writes.
`timescale 1ns/100ps
module stf_host_model (
  input  wire logic         ref_clk, // Clock.
  input  wire logic         go,      // Issue one write.
  input  wire logic [7:0]   addr,    // Offset.
  input  wire logic [7:0]   data,    // Byte.
  output stf_pkg::stf_cmd_t cmd      // Write to the device.
);
  import stf_pkg::*;
  initial cmd = '0;
  // Idle lines flip so a stale byte never looks like a valid write.
  always @(posedge ref_clk) begin
    cmd.wr <= go;
    cmd.addr <= go ? addr : ~cmd.addr;
    cmd.data <= go ? data : ~cmd.data;
  end
endmodule

// ===== stf_core_test.sv
// Self-checking bench for the startup-timeout fault handler.
`timescale 1ns/100ps
module stf_core_test;
  import stf_pkg::*;
  localparam int UNIT_CYCLES = 4;
  // Longest episode: six restarts at the widest delay code, with margin.
  localparam int WAIT_MAX    = 5000;
  logic       ref_clk = 0, srst = 1, go = 0, on_cmd = 1, uv_ok_pin = 0;
  logic       limit_zero = 0, timeout_pin = 0, other_fault = 0;
  logic [7:0] addr = 0, data = 0, action_rd;
  stf_cmd_t   cmd;
  stf_clear_t clr = '0;
  logic       out_en, fault_latched, fault_seen;
  logic [2:0] attempts;
  int         num_errors = 0, comparisons = 0;
  stf_core #(
    .UNIT_CYCLES (UNIT_CYCLES)
  ) i_dut (
    .ref_clk       (ref_clk),
    .srst          (srst),
    .cmd           (cmd),
    .clr           (clr),
    .on_cmd        (on_cmd),
    .uv_ok_pin     (uv_ok_pin),
    .limit_zero    (limit_zero),
    .timeout_pin   (timeout_pin),
    .other_fault   (other_fault),
    .action_rd     (action_rd),
    .out_en        (out_en),
    .fault_latched (fault_latched),
    .fault_seen    (fault_seen),
    .attempts      (attempts)
  );
  stf_host_model i_host (
    .ref_clk (ref_clk),
    .go      (go),
    .addr    (addr),
    .data    (data),
    .cmd     (cmd)
  );
  always #50 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge ref_clk);
    #10;
  endtask
  task automatic wr(input logic [7:0] a, d);
    go = 1;
    addr = a;
    data = d;
    tick();
    go = 0;
    tick(3);
  endtask
  // Latch-off never restarts and continuous retry keeps no count.
  function automatic logic [2:0] exp_att(input logic [7:0] a);
    if (a[7:6] == STF_RESP_LATCH || a[5:3] == STF_RETRY_FOREVER) begin
      return 3'h0;
    end
    return a[5:3];
  endfunction
  task automatic clear_ep(input int kind);
    timeout_pin = 0;
    uv_ok_pin = 1;
    tick(4);
    if (kind == 4) begin
      on_cmd = 0;
      tick();
      on_cmd = 1;
    end else begin
      clr = stf_clear_t'(4'h8 >> kind);
    end
    tick();
    clr = '0;
    tick(4);
    check("latch cleared", fault_latched, 8'h0);
    check("attempts cleared", attempts, 8'h0);
    uv_ok_pin = 0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] act;
    int         r, k;
    void'($urandom(32'h8557d5ef));
    tick(12);
    srst = 0;
    check("action reset", action_rd, STF_ACTION_RESET);
    wr(8'h64 + 8'($urandom_range(0, 100)), 8'($urandom));
    check("unmapped write", action_rd, STF_ACTION_RESET);
    // Retry codes 0 to 7 first, then each response code in turn.
    for (r = 0; r < 12; r++) begin
      act = {r < 8 ? STF_RESP_RETRY : 2'(r - 8), 3'(r),
             3'($urandom_range(0, 7))};
      wr(STF_ACTION_OFFSET, act);
      check("action readback", action_rd, act);
      limit_zero = (r == 0);
      timeout_pin = 1;
      // Two sync stages, one state step, one output register.
      tick(4);
      check("fault seen", fault_seen, {7'h0, r != 0});
      check("early out_en", out_en, {7'h0, r == 0 || !act[7]});
      check("early latch", fault_latched, {7'h0, &act[7:6]});
      limit_zero = 0;
      if (act[7:6] == STF_RESP_IGNORE) begin
        tick(200);
        check("ignored", {out_en, fault_latched}, 8'h2);
      end else begin
        if (act[5:3] == STF_RETRY_FOREVER) begin
          tick(600);
          check("retrying", fault_latched, 8'h0);
          on_cmd = 0;
        end
        for (k = 0; k < WAIT_MAX && fault_latched !== 1'b1; k++) tick();
        check("latch wait", fault_latched, 8'h1);
        if (k == WAIT_MAX) summarize();
        check("attempts", attempts, exp_att(act));
      end
      clear_ep(act[5:3] == STF_RETRY_FOREVER ? 4 : r % 5);
    end
    summarize();
  end
endmodule
bind stf_core stf_core_monitor #(
  .UNIT_CYCLES (UNIT_CYCLES)
) i_mon (
  .ref_clk       (ref_clk),
  .srst          (srst),
  .cmd           (cmd),
  .clr           (clr),
  .on_cmd        (on_cmd),
  .uv_ok_pin     (uv_ok_pin),
  .limit_zero    (limit_zero),
  .timeout_pin   (timeout_pin),
  .other_fault   (other_fault),
  .action_rd     (action_rd),
  .out_en        (out_en),
  .fault_latched (fault_latched),
  .fault_seen    (fault_seen),
  .attempts      (attempts)
);
